// ===== include/vtar_consts.vh
// constants for the vlan table access register block
`ifndef VTAR_CONSTS_VH
`define VTAR_CONSTS_VH

`define VTAR_AW              16
`define VTAR_DW              32
`define VTAR_OFF_AGE_CFG     16'h1809
`define VTAR_OFF_CMD         16'h180B
`define VTAR_OFF_WR_DATA     16'h180C
`define VTAR_OFF_CMD_STATUS  16'h180D
`define VTAR_OFF_RD_DATA     16'h180E

`define VTAR_AGE_TEST_BIT    0
`define VTAR_CMD_DIR_BIT     5
`define VTAR_CMD_SEL_BIT     4
`define VTAR_CMD_IDX_HI      3
`define VTAR_CMD_IDX_LO      0
`define VTAR_CMD_W           6
`define VTAR_STS_PEND_BIT    0

`define VTAR_ENTRY_W         18
`define VTAR_PVID_W          15
`define VTAR_VID_HI          11
`define VTAR_PRIO_HI         14
`define VTAR_PRIO_LO         12
`define VTAR_MEMBER_P2_BIT   17
`define VTAR_MEM_AW          5

`define VTAR_CLK_KHZ         100000
`define VTAR_AGE_NORMAL_MIN  5
`define VTAR_AGE_TEST_MS     50
`define VTAR_AGE_CNT_W       36

`define VTAR_RST_CMD         6'h00
`define VTAR_RST_DATA        18'h00000
`define VTAR_RST_WORD        32'h00000000

`endif

// ===== core/vtar_mem.v
// table storage: both tables in one array, registered read data
`default_nettype none
`include "vtar_consts.vh"

module vtar_mem (
	input  wire                      clock,
	input  wire                      we,
	input  wire                      re,
	input  wire [`VTAR_MEM_AW-1:0]   addr,
	input  wire [`VTAR_ENTRY_W-1:0]  wdata,
	output reg  [`VTAR_ENTRY_W-1:0]  rdata_q
);
	reg [`VTAR_ENTRY_W-1:0] mem [0:(1<<`VTAR_MEM_AW)-1];

	// no reset on the array; table contents are owned by software
	always @(posedge clock) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata_q <= mem[addr];
		end
	end
endmodule // vtar_mem

`default_nettype wire

// ===== core/vtar_top.v
// vlan table access registers, table sequencer and aging timer
//
// What this block does
// - aging period 50 ms in test, else 5 min
// - aging test bit 0, rw, reset zero
// - each command write starts one table access
// - read: poll pending, then fetch read data
// - command bit 5: one reads, zero writes
// - command bit 4 picks default-id table
// - bits 3:0 index; software keeps in range
// - default-id entry: vid 11:0, priority 14:12
// - vlan entry bit 17 marks port 2 member
//
// The implementer's own choice: the strobed register port.
`default_nettype none
`include "vtar_consts.vh"

module vtar_top #(
	parameter [`VTAR_AGE_CNT_W-1:0] AGE_NORMAL_CYC =
		`VTAR_AGE_NORMAL_MIN * 36'd60 * 36'd1000 * `VTAR_CLK_KHZ,
	parameter [`VTAR_AGE_CNT_W-1:0] AGE_TEST_CYC =
		`VTAR_AGE_TEST_MS * 36'd1 * `VTAR_CLK_KHZ
) (
	input  wire                      clock,
	input  wire                      rst,
	input  wire [`VTAR_AW-1:0]       reg_addr,
	input  wire [`VTAR_DW-1:0]       reg_wdata,
	input  wire                      reg_wr,
	input  wire                      reg_rd,
	output reg  [`VTAR_DW-1:0]       reg_rdata_q,
	output reg                       aging_test_shorten_q,
	output reg                       aging_tick_q,
	output reg                       table_busy_q
);
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_RUN  = 3'b010;
	localparam [2:0] S_CAP  = 3'b100;

	reg  [2:0]                  state_q;
	reg  [2:0]                  state_d;
	reg  [`VTAR_CMD_W-1:0]      cmd_q;
	reg  [`VTAR_ENTRY_W-1:0]    wr_data_q;
	reg  [`VTAR_ENTRY_W-1:0]    rd_data_q;
	reg                         pending_q;
	reg  [`VTAR_AGE_CNT_W-1:0]  age_cnt_q;
	reg                         age_test_last_q;
	wire [`VTAR_ENTRY_W-1:0]    mem_rdata;
	wire                        cmd_wr;
	wire                        dir_read;
	wire                        sel_pvid;
	wire [`VTAR_AGE_CNT_W-1:0]  age_period;
	reg  [`VTAR_DW-1:0]         rdata_d;

	function hit;
		input [`VTAR_AW-1:0] a;
		input [`VTAR_AW-1:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// default-id entries keep only vid and priority, upper bits reserved
	function [`VTAR_ENTRY_W-1:0] entry_mask;
		input                      pvid;
		input [`VTAR_ENTRY_W-1:0]  d;
		begin
			if (pvid) begin
				entry_mask = {{(`VTAR_ENTRY_W-`VTAR_PVID_W){1'b0}},
					d[`VTAR_PRIO_HI:`VTAR_PRIO_LO], d[`VTAR_VID_HI:0]};
			end else begin
				entry_mask = d;
			end
		end
	endfunction

	function [`VTAR_DW-1:0] widen;
		input [`VTAR_ENTRY_W-1:0] d;
		begin
			widen = {{(`VTAR_DW-`VTAR_ENTRY_W){1'b0}}, d};
		end
	endfunction

	assign cmd_wr   = reg_wr && hit(reg_addr, `VTAR_OFF_CMD);
	assign dir_read = cmd_q[`VTAR_CMD_DIR_BIT];
	assign sel_pvid = cmd_q[`VTAR_CMD_SEL_BIT];

	// index used as given; out-of-range ports land in spare words
	vtar_mem vtar_mem_i (
		.clock   (clock),
		.we      (state_q[2'd1] && !dir_read),
		.re      (state_q[2'd1] && dir_read),
		.addr    ({sel_pvid, cmd_q[`VTAR_CMD_IDX_HI:`VTAR_CMD_IDX_LO]}),
		.wdata   (entry_mask(sel_pvid, wr_data_q)),
		.rdata_q (mem_rdata)
	);

	// a command written mid-access restarts the sequence with the new value
	always @* begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (cmd_wr) begin
					state_d = S_RUN;
				end
			end
			S_RUN: begin
				if (cmd_wr) begin
					state_d = S_RUN;
				end else begin
					state_d = S_CAP;
				end
			end
			S_CAP: begin
				if (cmd_wr) begin
					state_d = S_RUN;
				end else begin
					state_d = S_IDLE;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	always @(posedge clock) begin
		if (rst) begin
			state_q      <= S_IDLE;
			cmd_q        <= `VTAR_RST_CMD;
			wr_data_q    <= `VTAR_RST_DATA;
			rd_data_q    <= `VTAR_RST_DATA;
			pending_q    <= 1'b0;
			table_busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (cmd_wr) begin
				cmd_q <= reg_wdata[`VTAR_CMD_W-1:0];
			end
			// write data held for the next command
			if (reg_wr && hit(reg_addr, `VTAR_OFF_WR_DATA)) begin
				wr_data_q <= reg_wdata[`VTAR_ENTRY_W-1:0];
			end
			// read data filled on the same clock edge that pending drops
			if (state_q[2'd2] && dir_read && !cmd_wr) begin
				rd_data_q <= mem_rdata;
			end
			if (cmd_wr) begin
				pending_q <= 1'b1;
			end else if (state_q[2'd2]) begin
				pending_q <= 1'b0;
			end
			table_busy_q <= (state_d != S_IDLE);
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			aging_test_shorten_q <= 1'b0;
		end else if (reg_wr && hit(reg_addr, `VTAR_OFF_AGE_CFG)) begin
			aging_test_shorten_q <= reg_wdata[`VTAR_AGE_TEST_BIT];
		end
	end

	assign age_period = aging_test_shorten_q ? AGE_TEST_CYC : AGE_NORMAL_CYC;

	// switching modes restarts the period so a long count cannot overrun
	always @(posedge clock) begin
		if (rst) begin
			age_cnt_q       <= {`VTAR_AGE_CNT_W{1'b0}};
			age_test_last_q <= 1'b0;
			aging_tick_q    <= 1'b0;
		end else begin
			age_test_last_q <= aging_test_shorten_q;
			if (age_test_last_q != aging_test_shorten_q) begin
				age_cnt_q    <= {`VTAR_AGE_CNT_W{1'b0}};
				aging_tick_q <= 1'b0;
			end else if (age_cnt_q >= age_period - 36'd1) begin
				age_cnt_q    <= {`VTAR_AGE_CNT_W{1'b0}};
				aging_tick_q <= 1'b1;
			end else begin
				age_cnt_q    <= age_cnt_q + 36'd1;
				aging_tick_q <= 1'b0;
			end
		end
	end

	// read mux; unmapped addresses answer zero
	always @* begin
		rdata_d = `VTAR_RST_WORD;
		if (hit(reg_addr, `VTAR_OFF_AGE_CFG)) begin
			rdata_d[`VTAR_AGE_TEST_BIT] = aging_test_shorten_q;
		end else if (hit(reg_addr, `VTAR_OFF_CMD)) begin
			rdata_d[`VTAR_CMD_W-1:0] = cmd_q;
		end else if (hit(reg_addr, `VTAR_OFF_WR_DATA)) begin
			rdata_d = widen(wr_data_q);
		end else if (hit(reg_addr, `VTAR_OFF_CMD_STATUS)) begin
			rdata_d[`VTAR_STS_PEND_BIT] = pending_q;
		end else if (hit(reg_addr, `VTAR_OFF_RD_DATA)) begin
			rdata_d = widen(rd_data_q);
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			reg_rdata_q <= `VTAR_RST_WORD;
		end else if (reg_rd) begin
			reg_rdata_q <= rdata_d;
		end else begin
			reg_rdata_q <= `VTAR_RST_WORD;
		end
	end
endmodule // vtar_top

`default_nettype wire

// ===== test/vtar_chk.sv
// port checker for the vlan table access register block
`default_nettype none
module vtar_chk #(
	parameter [35:0] AGE_NORMAL_CYC = 36'd40,
	parameter [35:0] AGE_TEST_CYC   = 36'd8
) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata_q,
	input wire logic        aging_test_shorten_q,
	input wire logic        aging_tick_q,
	input wire logic        table_busy_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
		else $error("read data not zero outside read");
	a_cfg_write: assert property (reg_wr && reg_addr == 16'h1809 |=>
		aging_test_shorten_q == $past(reg_wdata[0])) else $error("aging bit not written");
	a_cfg_read: assert property (reg_rd && reg_addr == 16'h1809 |=>
		reg_rdata_q == {31'h0, aging_test_shorten_q}) else $error("aging cfg read wrong");
	// busy and pending share c1..c2, so both checks lean on the same window
	a_cmd_pend: assert property (reg_wr && reg_addr == 16'h180B ##1
		(!reg_wr || reg_addr != 16'h180B) [*2] |->
		$past(table_busy_q) && table_busy_q ##1 !table_busy_q) else $error("access length wrong");
	a_sts_read: assert property (reg_rd && reg_addr == 16'h180D |=>
		reg_rdata_q == {31'h0, $past(table_busy_q)}) else $error("pending flag wrong");
	a_cmd_rsv: assert property (reg_rd && reg_addr == 16'h180B |=>
		reg_rdata_q[31:6] == 26'h0) else $error("command upper bits not zero");
	a_data_rsv: assert property (reg_rd && reg_addr inside {16'h180C, 16'h180E} |=>
		reg_rdata_q[31:18] == 14'h0) else $error("data upper bits not zero");
	// repetition count fixed at the bench value of AGE_TEST_CYC
	a_tick_test: assert property (aging_tick_q && aging_test_shorten_q &&
		$stable(aging_test_shorten_q) ##1 aging_test_shorten_q [*8] |-> aging_tick_q)
		else $error("short aging period wrong");
	a_tick_pulse: assert property (aging_tick_q |=> !aging_tick_q)
		else $error("aging tick too long");
	cover property (reg_wr && reg_addr == 16'h180B && reg_wdata[5]);
	cover property (reg_wr && reg_addr == 16'h180B && reg_wdata[4]);
	cover property (aging_tick_q && aging_test_shorten_q);
endmodule // vtar_chk
bind vtar_top vtar_chk #(.AGE_NORMAL_CYC(AGE_NORMAL_CYC), .AGE_TEST_CYC(AGE_TEST_CYC)) vtar_chk_i (
	.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.aging_test_shorten_q(aging_test_shorten_q), .aging_tick_q(aging_tick_q),
	.table_busy_q(table_busy_q));
`default_nettype wire

// ===== test/vtar_top_test.sv
// self-checking bench for the vlan table access register block
`default_nettype none
module vtar_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] reg_addr = 16'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	wire  [31:0] reg_rdata_q;
	wire         aging_test_shorten_q;
	wire         aging_tick_q;
	wire         table_busy_q;
	logic        rd_seen = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] mem_e[19];
	logic [31:0] rnd = 32'h1889;
	int          err_count = 0;
	int          compares = 0;
	int          cyc = 0;
	vtar_top #(.AGE_NORMAL_CYC(36'd40), .AGE_TEST_CYC(36'd8)) vtar_top_i (
		.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.aging_test_shorten_q(aging_test_shorten_q), .aging_tick_q(aging_tick_q),
		.table_busy_q(table_busy_q));
	always #5 clock = ~clock;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task chk(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task chk_gap(input int e, input int g);
		compares++;
		if (g != e) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge clock);
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		exp_q.push_back(e);
		@(posedge clock);
	endtask
	task idle;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clock);
	endtask
	// upper command bits set on purpose: they must be dropped
	task cmd(input logic [5:0] c);
		wr(16'h180B, 32'hFFFFFFC0 | c);
		rd(16'h180D, 32'h1);
		rd(16'h180D, 32'h1);
		rd(16'h180D, 32'h0);
	endtask
	task tgap(input int e);
		int n;
		n = 0;
		while (aging_tick_q !== 1'b1) @(negedge clock);
		do begin
			@(negedge clock);
			n++;
		end while (aging_tick_q !== 1'b1);
		chk_gap(e, n);
		// realign to the rising edge before the next bus cycle
		@(posedge clock);
	endtask
	task complete_run;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock) rd_seen <= reg_rd;
	// read data stands one cycle only, so it is taken at the falling edge
	always @(negedge clock) if (rd_seen) chk(exp_q.pop_front(), reg_rdata_q);
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run;
		end
	end
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(16'h1809, 32'h0);
		rd(16'h180B, 32'h0);
		wr(16'h1809, 32'hFFFFFFFF);
		rd(16'h1809, 32'h1);
		idle;
		tgap(8);
		wr(16'h1809, 32'hFFFFFFFE);
		rd(16'h1809, 32'h0);
		idle;
		tgap(40);
		$display("aging period test done");
		wr(16'h180A, 32'hFFFFFFFF);
		rd(16'h180A, 32'h0);
		rd(16'h1800, 32'h0);
		// entries 16..18 land on select bit 4 with port index 0..2
		for (int i = 0; i < 19; i++) begin
			rnd = xs(rnd);
			mem_e[i] = (i < 16) ? rnd & 32'h3FFFF : rnd & 32'h7FFF;
			wr(16'h180C, rnd);
			rd(16'h180C, rnd & 32'h3FFFF);
			cmd(6'(i));
			rd(16'h180B, 32'(i));
		end
		for (int i = 0; i < 19; i++) begin
			cmd(6'h20 | 6'(i));
			rd(16'h180E, mem_e[i]);
		end
		// a command right behind another replaces it mid-access
		wr(16'h180B, 32'h23);
		cmd(6'h25);
		rd(16'h180E, mem_e[5]);
		idle;
		$display("table access test done");
		repeat (2) @(posedge clock);
		complete_run;
	end
endmodule // vtar_top_test
`default_nettype wire
